// file: verilog/pmr_regs.vh
// Overview of operation
// - Bus voltage in bits 23..4, non-negative
// - Low four bits of voltage and current results read zero
// - Die temperature, 16-bit two's complement value
// - Current in bits 23..4, two's complement
// - Power unsigned 24 bits, bits 23..0
// - Energy unsigned 40 bits, bits 39..0
// - Charge two's complement 40 bits
// - Transparent mode: alert follows the fault
// - Latched mode: alert holds until diagnostic read
// - Ready routing bit puts ready flag on alert
// - Compare select chooses averaged or raw value
// - Polarity bit: active-low or active-high pin
// - Energy overflow set, cleared reading energy
// - Charge overflow set, cleared reading charge
// - Arithmetic overflow cleared by trigger or clear
// - Diagnostic bit 8 always reads zero
// - Temperature over-limit flag on threshold exceed
// - Shunt over-limit flag on threshold exceed
// - Latched mode: diagnostic read clears limit flags
// - Ready flag set on completion, cleared per mode
// - Trim checksum flag resets one, checksum error clears
// - Results update only when averaging completes
`ifndef PMR_REGS_VH
`define PMR_REGS_VH

`define PMR_ADDR_W            4
`define PMR_ADDR_BUS_VOLTAGE  4'h5
`define PMR_ADDR_DIE_TEMP     4'h6
`define PMR_ADDR_CURRENT      4'h7
`define PMR_ADDR_POWER        4'h8
`define PMR_ADDR_ENERGY       4'h9
`define PMR_ADDR_CHARGE       4'hA
`define PMR_ADDR_DIAG_ALERT   4'hB

`define PMR_BIT_ALERT_LATCH   15
`define PMR_BIT_READY_TO_PIN  14
`define PMR_BIT_AVG_COMPARE   13
`define PMR_BIT_ALERT_POL     12
`define PMR_BIT_ENERGY_OF     11
`define PMR_BIT_CHARGE_OF     10
`define PMR_BIT_MATH_OF       9
`define PMR_BIT_RESERVED8     8
`define PMR_BIT_TEMP_OL       7
`define PMR_BIT_SHUNT_OL      6
`define PMR_BIT_CONV_DONE     1
`define PMR_BIT_TRIM_OK       0

`define PMR_RESULT_LSB        4
`define PMR_DIAG_RST          16'h0001
`define PMR_RESULT_RST        40'h00_0000_0000
`define PMR_CTRL_RST          4'h0

`endif

// file: verilog/pmr_flag.v
`default_nettype none

module pmr_flag #(
    parameter [0:0] RST_VAL = 1'b0
) (
    input  wire clk_in,
    input  wire sys_rst_in,
    input  wire set_in,
    input  wire clr_in,
    output wire flag_out
);

    reg flag_r;

    // Set wins so an event on the clearing edge is kept
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_r <= RST_VAL;
        end else if (set_in) begin
            flag_r <= 1'b1;
        end else if (clr_in) begin
            flag_r <= 1'b0;
        end
    end

    assign flag_out = flag_r;

endmodule // pmr_flag

`default_nettype wire

// file: verilog/pmr_result_regs.v
`include "pmr_regs.vh"
`default_nettype none

module pmr_result_regs #(
    parameter VOLT_W   = 20,
    parameter TEMP_W   = 16,
    parameter CURR_W   = 20,
    parameter POWER_W  = 24,
    parameter ACC_W    = 40,
    parameter LIMIT_W  = 16
) (
    input  wire                   clk_in,
    input  wire                   sys_rst_in,
    // Register port from the serial engine
    input  wire [`PMR_ADDR_W-1:0] reg_addr_in,
    input  wire                   reg_rd_in,
    input  wire                   reg_wr_in,
    input  wire [15:0]            reg_wdata_in,
    output wire [ACC_W-1:0]       reg_rdata_out,
    output wire                   reg_rvalid_out,
    // Conversion engine events
    input  wire                   conv_start_in,
    input  wire                   sample_valid_in,
    input  wire                   avg_done_in,
    input  wire                   accumulator_clear_in,
    input  wire                   checksum_err_in,
    input  wire                   energy_ovf_in,
    input  wire                   charge_ovf_in,
    input  wire                   math_ovf_in,
    // Raw and averaged limit inputs
    input  wire [LIMIT_W-1:0]     shunt_sample_in,
    input  wire [LIMIT_W-1:0]     shunt_avg_in,
    input  wire [TEMP_W-1:0]      temp_sample_in,
    input  wire [LIMIT_W-1:0]     shunt_limit_in,
    input  wire [TEMP_W-1:0]      temp_limit_in,
    // Averaged results
    input  wire [VOLT_W-1:0]      bus_voltage_value_in,
    input  wire [TEMP_W-1:0]      die_temp_value_in,
    input  wire [CURR_W-1:0]      current_value_in,
    input  wire [POWER_W-1:0]     power_value_in,
    input  wire [ACC_W-1:0]       energy_value_in,
    input  wire [ACC_W-1:0]       charge_value_in,
    // Open-drain alert pin
    output wire                   alert_pin_out,
    output wire                   alert_oe_out
);

    // Signed greater-than, shared by both limit comparators
    function over_limit;
        input [LIMIT_W-1:0] value;
        input [LIMIT_W-1:0] limit;
        begin
            over_limit = ($signed(value) > $signed(limit));
        end
    endfunction

    function addr_hit;
        input [`PMR_ADDR_W-1:0] addr;
        input [`PMR_ADDR_W-1:0] target;
        input                   strobe;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    // Zero reset cut to each result width
    localparam [ACC_W-1:0] RESULT_RST = `PMR_RESULT_RST;

    reg  [VOLT_W-1:0]   bus_voltage_result_r;
    reg  [TEMP_W-1:0]   die_temperature_result_r;
    reg  [CURR_W-1:0]   current_result_r;
    reg  [POWER_W-1:0]  power_result_r;
    reg  [ACC_W-1:0]    energy_accumulator_r;
    reg  [ACC_W-1:0]    charge_accumulator_r;

    reg                 alert_latch_select_r;
    reg                 ready_to_pin_enable_r;
    reg                 averaged_compare_select_r;
    reg                 alert_pin_polarity_r;

    reg  [ACC_W-1:0]    rdata_r;
    reg  [ACC_W-1:0]    rdata_nxt;
    reg                 rvalid_r;
    reg                 alert_oe_r;

    wire                rd_diag;
    wire                rd_energy;
    wire                rd_charge;
    wire                wr_diag;
    wire                cmp_evt;
    wire [LIMIT_W-1:0]  shunt_cmp_value;
    wire [TEMP_W-1:0]   temp_cmp_value;
    wire                shunt_over;
    wire                temp_over;
    wire                limit_set_clr_shunt;
    wire                limit_set_clr_temp;
    wire                energy_overflow_flag;
    wire                charge_overflow_flag;
    wire                arithmetic_overflow_flag;
    wire                temp_over_limit_flag;
    wire                shunt_over_limit_flag;
    wire                conversion_done_flag;
    wire                trim_checksum_ok;
    wire                alert_active;
    wire [15:0]         diagnostic_alert_reg;

    assign rd_diag   = addr_hit(reg_addr_in, `PMR_ADDR_DIAG_ALERT, reg_rd_in);
    assign rd_energy = addr_hit(reg_addr_in, `PMR_ADDR_ENERGY, reg_rd_in);
    assign rd_charge = addr_hit(reg_addr_in, `PMR_ADDR_CHARGE, reg_rd_in);
    assign wr_diag   = addr_hit(reg_addr_in, `PMR_ADDR_DIAG_ALERT, reg_wr_in);

    // Results move only when the averaging sequence is over
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            bus_voltage_result_r     <= RESULT_RST[VOLT_W-1:0];
            die_temperature_result_r <= RESULT_RST[TEMP_W-1:0];
            current_result_r         <= RESULT_RST[CURR_W-1:0];
            power_result_r           <= RESULT_RST[POWER_W-1:0];
            energy_accumulator_r     <= RESULT_RST;
            charge_accumulator_r     <= RESULT_RST;
        end else if (avg_done_in) begin
            bus_voltage_result_r     <= bus_voltage_value_in;
            die_temperature_result_r <= die_temp_value_in;
            current_result_r         <= current_value_in;
            power_result_r           <= power_value_in;
            energy_accumulator_r     <= energy_value_in;
            charge_accumulator_r     <= charge_value_in;
        end
    end

    // Alert control bits, the only writable part of the register
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            alert_latch_select_r      <= 1'b0;
            ready_to_pin_enable_r     <= 1'b0;
            averaged_compare_select_r <= 1'b0;
            alert_pin_polarity_r      <= 1'b0;
        end else if (wr_diag) begin
            alert_latch_select_r      <= reg_wdata_in[`PMR_BIT_ALERT_LATCH];
            ready_to_pin_enable_r     <= reg_wdata_in[`PMR_BIT_READY_TO_PIN];
            averaged_compare_select_r <= reg_wdata_in[`PMR_BIT_AVG_COMPARE];
            alert_pin_polarity_r      <= reg_wdata_in[`PMR_BIT_ALERT_POL];
        end
    end

    // Raw compares react faster, averaged ones ride out noise
    assign cmp_evt         = averaged_compare_select_r ? avg_done_in : sample_valid_in;
    assign shunt_cmp_value = averaged_compare_select_r ? shunt_avg_in : shunt_sample_in;
    assign temp_cmp_value  = averaged_compare_select_r ? die_temp_value_in
                                                       : temp_sample_in;

    assign shunt_over = cmp_evt && over_limit(shunt_cmp_value, shunt_limit_in);
    assign temp_over  = cmp_evt && over_limit(temp_cmp_value, temp_limit_in);

    // Transparent mode follows each compare; latched waits for a read
    assign limit_set_clr_shunt = alert_latch_select_r ? rd_diag
                                                      : (cmp_evt && !shunt_over);
    assign limit_set_clr_temp  = alert_latch_select_r ? rd_diag
                                                      : (cmp_evt && !temp_over);

    pmr_flag #(
        .RST_VAL    (1'b0)
    ) u_shunt_ol (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (shunt_over),
        .clr_in     (limit_set_clr_shunt),
        .flag_out   (shunt_over_limit_flag)
    );

    pmr_flag #(
        .RST_VAL    (1'b0)
    ) u_temp_ol (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (temp_over),
        .clr_in     (limit_set_clr_temp),
        .flag_out   (temp_over_limit_flag)
    );

    // Ready flag also falls at a new trigger in either mode
    pmr_flag #(
        .RST_VAL    (1'b0)
    ) u_conv_done (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (avg_done_in),
        .clr_in     (conv_start_in || (alert_latch_select_r && rd_diag)),
        .flag_out   (conversion_done_flag)
    );

    pmr_flag #(
        .RST_VAL    (1'b0)
    ) u_energy_of (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (energy_ovf_in),
        .clr_in     (rd_energy),
        .flag_out   (energy_overflow_flag)
    );

    pmr_flag #(
        .RST_VAL    (1'b0)
    ) u_charge_of (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (charge_ovf_in),
        .clr_in     (rd_charge),
        .flag_out   (charge_overflow_flag)
    );

    // Reading does not clear this one; only a trigger or clear does
    pmr_flag #(
        .RST_VAL    (1'b0)
    ) u_math_of (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (math_ovf_in),
        .clr_in     (conv_start_in || accumulator_clear_in),
        .flag_out   (arithmetic_overflow_flag)
    );

    // Sticky low until the next reset
    pmr_flag #(
        .RST_VAL    (1'b1)
    ) u_trim_ok (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (1'b0),
        .clr_in     (checksum_err_in),
        .flag_out   (trim_checksum_ok)
    );

    assign diagnostic_alert_reg = {
        alert_latch_select_r,
        ready_to_pin_enable_r,
        averaged_compare_select_r,
        alert_pin_polarity_r,
        energy_overflow_flag,
        charge_overflow_flag,
        arithmetic_overflow_flag,
        1'b0,
        temp_over_limit_flag,
        shunt_over_limit_flag,
        4'h0,
        conversion_done_flag,
        trim_checksum_ok
    };

    // Read mux; value is taken before any read-clear lands
    always @* begin
        rdata_nxt = {ACC_W{1'b0}};
        case (reg_addr_in)
            `PMR_ADDR_BUS_VOLTAGE: begin
                rdata_nxt = {{(ACC_W-VOLT_W-`PMR_RESULT_LSB){1'b0}},
                             bus_voltage_result_r, 4'h0};
            end
            `PMR_ADDR_DIE_TEMP: begin
                rdata_nxt = {{(ACC_W-TEMP_W){1'b0}}, die_temperature_result_r};
            end
            `PMR_ADDR_CURRENT: begin
                rdata_nxt = {{(ACC_W-CURR_W-`PMR_RESULT_LSB){1'b0}},
                             current_result_r, 4'h0};
            end
            `PMR_ADDR_POWER: begin
                rdata_nxt = {{(ACC_W-POWER_W){1'b0}}, power_result_r};
            end
            `PMR_ADDR_ENERGY: begin
                rdata_nxt = energy_accumulator_r;
            end
            `PMR_ADDR_CHARGE: begin
                rdata_nxt = charge_accumulator_r;
            end
            `PMR_ADDR_DIAG_ALERT: begin
                rdata_nxt = {{(ACC_W-16){1'b0}}, diagnostic_alert_reg};
            end
            default: begin
                rdata_nxt = {ACC_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_r  <= RESULT_RST;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_in;
            if (reg_rd_in) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Any limit flag, or ready when routed to the pin
    assign alert_active = temp_over_limit_flag || shunt_over_limit_flag ||
                          (ready_to_pin_enable_r && conversion_done_flag);

    // Open drain: the high level comes from the pull-up
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            alert_oe_r <= 1'b0;
        end else begin
            alert_oe_r <= alert_pin_polarity_r ? !alert_active : alert_active;
        end
    end

    assign alert_pin_out  = 1'b0;
    assign alert_oe_out   = alert_oe_r;
    assign reg_rdata_out  = rdata_r;
    assign reg_rvalid_out = rvalid_r;

endmodule // pmr_result_regs

`default_nettype wire

// file: verification/pmr_result_regs_chk.sv
`default_nettype none
module pmr_result_regs_chk #(
    parameter ACC_W   = 40,
    parameter LIMIT_W = 16
) (
    input wire logic               clk_in,
    input wire logic               sys_rst_in,
    input wire logic [3:0]         reg_addr_in,
    input wire logic               reg_rd_in,
    input wire logic               reg_wr_in,
    input wire logic [15:0]        reg_wdata_in,
    input wire logic [ACC_W-1:0]   reg_rdata_out,
    input wire logic               reg_rvalid_out,
    input wire logic               conv_start_in,
    input wire logic               sample_valid_in,
    input wire logic               avg_done_in,
    input wire logic               checksum_err_in,
    input wire logic               energy_ovf_in,
    input wire logic               charge_ovf_in,
    input wire logic               math_ovf_in,
    input wire logic [LIMIT_W-1:0] shunt_sample_in,
    input wire logic [LIMIT_W-1:0] shunt_limit_in,
    input wire logic               alert_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow of control bits 15..12, so alert checks know mode and polarity
    logic [3:0] cfg_r;
    always_ff @(posedge clk_in)
        if (sys_rst_in) cfg_r <= 4'h0;
        else if (reg_wr_in && reg_addr_in == 4'hB) cfg_r <= reg_wdata_in[15:12];
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_drd; reg_rd_in && reg_addr_in == 4'hB; endsequence
    property p_rvalid; reg_rd_in |=> reg_rvalid_out; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read gave no valid");
    property p_low_nib;
        reg_rd_in && (reg_addr_in == 4'h5 || reg_addr_in == 4'h7)
            |=> reg_rdata_out[3:0] == 4'h0 && reg_rdata_out[39:24] == 16'h0000;
    endproperty
    a_low_nib: assert property (p_low_nib) else $error("result low bits not zero");
    property p_diag8; s_drd |=> !reg_rdata_out[8] && reg_rdata_out[39:16] == 24'h0; endproperty
    a_diag8: assert property (p_diag8) else $error("diag bit 8 set");
    property p_energy; energy_ovf_in ##1 s_drd |=> reg_rdata_out[11]; endproperty
    a_energy: assert property (p_energy) else $error("energy overflow not set");
    property p_charge; charge_ovf_in ##1 s_drd |=> reg_rdata_out[10]; endproperty
    a_charge: assert property (p_charge) else $error("charge overflow not set");
    property p_math; math_ovf_in ##1 s_drd |=> reg_rdata_out[9]; endproperty
    a_math: assert property (p_math) else $error("math overflow not set");
    property p_trim; checksum_err_in ##1 s_drd |=> !reg_rdata_out[0]; endproperty
    a_trim: assert property (p_trim) else $error("checksum flag still one");
    property p_ready; avg_done_in ##1 s_drd |=> reg_rdata_out[1]; endproperty
    a_ready: assert property (p_ready) else $error("ready flag not set");
    property p_alert;
        avg_done_in && cfg_r[2] && !reg_wr_in ##1 !conv_start_in && !reg_wr_in
            |=> alert_oe_out == !cfg_r[0];
    endproperty
    a_alert: assert property (p_alert) else $error("alert pin wrong on ready");
    property p_shunt;
        sample_valid_in && !cfg_r[1] && $signed(shunt_sample_in) > $signed(shunt_limit_in)
            ##1 s_drd |=> reg_rdata_out[6];
    endproperty
    a_shunt: assert property (p_shunt) else $error("shunt flag not set");
    c_diag: cover property (s_drd);
    c_ready: cover property (avg_done_in && cfg_r[2]);
    c_energy: cover property (energy_ovf_in ##1 s_drd);
endmodule // pmr_result_regs_chk
bind pmr_result_regs pmr_result_regs_chk #(.ACC_W(ACC_W), .LIMIT_W(LIMIT_W)) u_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .conv_start_in(conv_start_in), .sample_valid_in(sample_valid_in),
    .avg_done_in(avg_done_in), .checksum_err_in(checksum_err_in),
    .energy_ovf_in(energy_ovf_in), .charge_ovf_in(charge_ovf_in),
    .math_ovf_in(math_ovf_in), .shunt_sample_in(shunt_sample_in),
    .shunt_limit_in(shunt_limit_in), .alert_oe_out(alert_oe_out));
`default_nettype wire

// file: verification/pmr_host.sv
`default_nettype none
module pmr_host (
    input  wire logic        clk_in,
    input  wire logic [39:0] rdata_in,
    input  wire logic        rvalid_in,
    output var  logic [3:0]  addr_out,
    output var  logic        rd_out,
    output var  logic        wr_out,
    output var  logic [15:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_out = 4'h0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 16'h0000;
    end
    // Entered at a falling edge; released lines show the inverse
    task automatic rd(input logic [3:0] a, output logic [39:0] d);
        int n;
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        addr_out = ~a;
        n = 0;
        while (rvalid_in !== 1'b1 && n < 8) begin
            @(negedge clk_in);
            n++;
        end
        d = (rvalid_in === 1'b1) ? rdata_in : 40'hX;
        // Let an edge pass so a following call never re-raises the strobe at once
        @(negedge clk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        addr_out = a;
        wdata_out = v;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~v;
        @(negedge clk_in);
    endtask
endmodule // pmr_host
`default_nettype wire

// file: verification/power_monitor_result_and_alert_regs_test.sv
`default_nettype none
module power_monitor_result_and_alert_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [39:0] M = 40'hFF_FFFF_FFFF;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] ev_r = 8'h00;
    logic [15:0] smp = 16'h0, savg = 16'h0, tsmp = 16'h0, slim = 16'h0100, tlim = 16'h0200;
    logic [19:0] volt = 20'h0, curr = 20'h0;
    logic [15:0] temp = 16'h0;
    logic [23:0] pwr = 24'h0;
    logic [39:0] nrg = 40'h0, chg = 40'h0, d;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic rd, wr;
    wire logic [39:0] rdata;
    wire logic rvalid, oe, apin, pin;
    int failures = 0;
    int num_checks = 0;
    // Pull-up on the shared alert wire
    assign pin = oe ? apin : 1'b1;
    always #12.5 clk_in = ~clk_in;
    pmr_host host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
        .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
    pmr_result_regs dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_rd_in(rd),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .conv_start_in(ev_r[7]), .sample_valid_in(ev_r[6]), .avg_done_in(ev_r[5]),
        .accumulator_clear_in(ev_r[4]), .checksum_err_in(ev_r[3]), .energy_ovf_in(ev_r[2]),
        .charge_ovf_in(ev_r[1]), .math_ovf_in(ev_r[0]), .shunt_sample_in(smp),
        .shunt_avg_in(savg), .temp_sample_in(tsmp), .shunt_limit_in(slim),
        .temp_limit_in(tlim), .bus_voltage_value_in(volt), .die_temp_value_in(temp),
        .current_value_in(curr), .power_value_in(pwr), .energy_value_in(nrg),
        .charge_value_in(chg), .alert_pin_out(apin), .alert_oe_out(oe));
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [39:0] m, e, input string n);
        host.rd(a, d);
        chk(n, e, d & m);
    endtask
    // Event bits: start, sample, avg, acc clear, checksum, energy, charge, math
    task automatic ev(input logic [7:0] m);
        ev_r = m;
        @(negedge clk_in);
        ev_r = 8'h00;
    endtask
    task automatic t_reset;
        for (int a = 5; a < 12; a++) rdc(a[3:0], M, (a == 11) ? 40'h1 : 40'h0, "reset");
        rdc(4'h3, M, 40'h0, "unmapped");
        chk("pin idle", 40'h1, {39'h0, pin});
    endtask
    task automatic t_results;
        volt = 20'hABCDE;
        temp = 16'hFF80;
        curr = 20'h80001;
        pwr = 24'hFEDCBA;
        nrg = 40'hF0_1234_5678;
        chg = 40'h80_0000_0001;
        ev(8'h20);
        @(negedge clk_in);
        // Raw sample alone must not move results
        volt = 20'h00001;
        ev(8'h40);
        rdc(4'h5, M, 40'hA_BCDE0, "volt");
        rdc(4'h6, M, 40'hFF80, "temp");
        rdc(4'h7, M, 40'h80_0010, "curr");
        rdc(4'h8, M, 40'hFE_DCBA, "power");
        rdc(4'h9, M, 40'hF0_1234_5678, "energy");
        rdc(4'hA, M, 40'h80_0000_0001, "charge");
    endtask
    task automatic t_ovf;
        ev(8'h07);
        rdc(4'hB, 40'hF00, 40'hE00, "ovf set");
        host.rd(4'h9, d);
        rdc(4'hB, 40'hF00, 40'h600, "energy read");
        host.rd(4'hA, d);
        rdc(4'hB, 40'hF00, 40'h200, "charge read");
        ev(8'h80);
        rdc(4'hB, 40'h200, 40'h0, "math by start");
        ev(8'h01);
        rdc(4'hB, 40'h200, 40'h200, "math again");
        ev(8'h10);
        rdc(4'hB, 40'h200, 40'h0, "math by clear");
    endtask
    task automatic t_limits;
        smp = 16'h0101;
        ev(8'h40);
        rdc(4'hB, 40'hC0, 40'h40, "shunt over");
        // Equal to the limit is not over
        smp = 16'h0100;
        tsmp = 16'h0201;
        ev(8'h40);
        rdc(4'hB, 40'hC0, 40'h80, "temp over");
        host.wr(4'hB, 16'h2000);
        smp = 16'h7FFF;
        tsmp = 16'h0000;
        ev(8'h40);
        rdc(4'hB, 40'h40, 40'h0, "raw ignored");
        savg = 16'h0101;
        ev(8'h20);
        rdc(4'hB, 40'h40, 40'h40, "avg over");
    endtask
    task automatic t_latch;
        host.wr(4'hB, 16'h8000);
        host.rd(4'hB, d);
        smp = 16'h0101;
        ev(8'h40);
        smp = 16'h0000;
        @(negedge clk_in);
        ev(8'h40);
        chk("pin held", 40'h0, {39'h0, pin});
        rdc(4'hB, 40'hC2, 40'h40, "latched");
        rdc(4'hB, 40'hC2, 40'h0, "read clears");
        chk("pin released", 40'h1, {39'h0, pin});
        ev(8'h20);
        rdc(4'hB, 40'h2, 40'h2, "ready set");
        rdc(4'hB, 40'h2, 40'h0, "ready read");
        ev(8'h20);
        @(negedge clk_in);
        ev(8'h80);
        rdc(4'hB, 40'h2, 40'h0, "ready start");
    endtask
    task automatic t_pol;
        host.wr(4'hB, 16'h4000);
        ev(8'h20);
        @(negedge clk_in);
        chk("ready on pin", 40'h0, {39'h0, pin});
        host.wr(4'hB, 16'h5000);
        @(negedge clk_in);
        chk("active high", 40'h1, {39'h0, pin});
        host.wr(4'hB, 16'h1000);
        @(negedge clk_in);
        chk("not routed", 40'h0, {39'h0, pin});
        ev(8'h08);
        rdc(4'hB, 40'h1, 40'h0, "trim error");
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_reset;
        t_results;
        t_ovf;
        t_limits;
        t_latch;
        t_pol;
        summarize;
    end
    // Whole run needs about 115 cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        failures++;
        summarize;
    end
endmodule // power_monitor_result_and_alert_regs_test
`default_nettype wire
